// ### include/apl_pkg.sv
// constants, register map and types of the axis position loop
package apl_pkg;

  // ***************************
  // axis count and scaling
  // ***************************
  localparam int AXES = 5;
  // one position count is one micron
  localparam int FE_LIMIT_MM = 32;
  localparam logic [32:0] FE_LIMIT_UM = 33'(FE_LIMIT_MM * 1000);
  // 2.5 mV per micron at gain 64 on a +/-10 V 16-bit converter: 0.128 lsb per gain-micron
  localparam logic [7:0] DAC_MUL = 8'h83;
  localparam int DAC_SHIFT = 10;
  localparam int FF_SHIFT = 6;
  localparam logic signed [15:0] DAC_MAX = 16'sh7fff;
  localparam logic signed [15:0] DAC_MIN = 16'sh8000;
  // reference point: gain 64 and 1 micron give 8 lsb (2.44 mV)
  localparam logic [7:0] GAIN_REF = 8'h40;
  localparam logic signed [15:0] GAIN_REF_LSB = 16'sh0008;

  // ***************************
  // register map (byte offsets)
  // ***************************
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_ALARM = 8'h0c;
  // axis n occupies 16 bytes at slot AXIS_SLOT0 + n
  localparam logic [3:0] AXIS_SLOT0 = 4'h2;
  localparam logic [3:0] OFS_GAINS = 4'h0;
  localparam logic [3:0] OFS_BREAK = 4'h4;
  localparam logic [3:0] OFS_RAPID = 4'h8;
  localparam logic [3:0] OFS_FERR = 4'hc;

  // ***************************
  // reset values
  // ***************************
  localparam logic [7:0] RST_LOW_GAIN = 8'h40;
  localparam logic [7:0] RST_HIGH_GAIN = 8'h40;
  localparam logic [7:0] RST_FF_GAIN = 8'h00;
  localparam logic [15:0] RST_BREAK = 16'h03e8;
  localparam logic [15:0] RST_RAPID = 16'hffff;

  // ***************************
  // types
  // ***************************
  typedef struct packed {
    logic [7:0] feed_forward_gain;
    logic [7:0] high_error_gain;
    logic [7:0] low_error_gain;
    logic [15:0] gain_break_point;
    logic [15:0] max_rapid_feed;
  } apl_axis_cfg_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_DONE = 2'b11
  } apl_rd_state_t;

endpackage : apl_pkg

// ### hw/apl_axis_gain.sv
// one axis: following error, dual-slope gain, feed-forward, saturation, alarm
`timescale 1ns/1ps
module apl_axis_gain (
  // clock and reset
  input logic clk_in,
  input logic rst_in,
  // settings of this axis only
  input apl_pkg::apl_axis_cfg_t cfg_in,
  // positions in microns, signed feedrate
  input logic signed [31:0] cmd_pos_in,
  input logic signed [31:0] meas_pos_in,
  input logic signed [15:0] feed_in,
  input logic accel_active_in,
  // results
  output logic signed [15:0] analog_out,
  output logic alarm_out,
  output logic [31:0] ferr_out
);
  import apl_pkg::*;

  logic signed [32:0] err;
  logic [32:0] mag, bp, mag_lo, excess;
  logic above;
  logic [41:0] prop;
  logic [49:0] scaled;
  logic [39:0] volts;
  logic [15:0] prop_mag, feed_mag, feed_c;
  logic [23:0] ff_prod;
  logic [17:0] ff_mag;
  logic signed [19:0] prop_s, ff_s, total;
  logic signed [15:0] next_analog;
  logic next_alarm;
  logic [31:0] next_ferr;

  // ***************************
  // loop arithmetic
  // ***************************
  // 33-bit error so opposite full-scale positions cannot wrap
  always_comb begin
    err = 33'(cmd_pos_in) - 33'(meas_pos_in);
    mag = err[32] ? 33'(-err) : 33'(err);
    bp = {17'h0, cfg_in.gain_break_point};
    above = mag > bp;
    // low slope up to break point
    mag_lo = above ? bp : mag;
    // high slope on the excess only
    excess = above ? mag - bp : 33'h0;
    prop = 42'(cfg_in.low_error_gain) * 42'(mag_lo) + 42'(cfg_in.high_error_gain) * 42'(excess);
    // gain 64 scales to 2.5 mV per micron
    scaled = 50'(prop) * 50'(DAC_MUL);
    volts = scaled[49:DAC_SHIFT];
    prop_mag = (volts > 40'(DAC_MAX)) ? DAC_MAX : volts[15:0];
    // command takes the sign of the error
    prop_s = err[32] ? -$signed(20'(prop_mag)) : $signed(20'(prop_mag));
    // feedrate is clipped to this axis's rapid limit before feed-forward
    feed_mag = feed_in[15] ? 16'(-feed_in) : 16'(feed_in);
    feed_c = (feed_mag > cfg_in.max_rapid_feed) ? cfg_in.max_rapid_feed : feed_mag;
    ff_prod = 24'(cfg_in.feed_forward_gain) * 24'(feed_c);
    ff_mag = ff_prod[23:FF_SHIFT];
    if (!accel_active_in) begin
      ff_s = 20'sh00000;
    end else if (feed_in[15]) begin
      ff_s = -$signed(20'(ff_mag));
    end else begin
      ff_s = $signed(20'(ff_mag));
    end
    total = prop_s + ff_s;
    if (total > 20'(DAC_MAX)) begin
      next_analog = DAC_MAX;
    end else if (total < 20'(DAC_MIN)) begin
      next_analog = DAC_MIN;
    end else begin
      next_analog = total[15:0];
    end
    next_alarm = mag > FE_LIMIT_UM;
    next_ferr = err[31:0];
  end

  // results registered once per clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      analog_out <= 16'sh0000;
      alarm_out <= 1'b0;
      ferr_out <= 32'h0;
    end else begin
      analog_out <= next_analog;
      alarm_out <= next_alarm;
      ferr_out <= next_ferr;
    end
  end

  // ***************************
  // checks
  // ***************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  alarm_limit_a: assert property ((mag > FE_LIMIT_UM) |=> alarm_out ##0 $past(err) != 33'sh0)
    else $error("alarm missing above 32 mm");
  alarm_clear_a: assert property ((mag <= FE_LIMIT_UM) |=> !alarm_out)
    else $error("alarm raised within limit");
  gain_ref_a: assert property ((!above && mag == 33'h1 && !err[32] && cfg_in.low_error_gain == GAIN_REF
      && !accel_active_in) |=> analog_out == GAIN_REF_LSB)
    else $error("gain 64 at 1 micron not 8 lsb");
  low_slope_a: assert property ((!above && !accel_active_in && cfg_in.low_error_gain == 8'h00) |=>
      analog_out == 16'sh0000)
    else $error("low slope ignored its gain");
  break_flat_a: assert property ((above && cfg_in.high_error_gain == 8'h00 && !accel_active_in
      && !err[32])[*2] ##0 $stable(cfg_in) |=> $stable(analog_out))
    else $error("excess over break point not on high gain");
  sign_follow_a: assert property ((!accel_active_in && err[32]) |=> analog_out <= 16'sh0000)
    else $error("command sign differs from error");
  no_ff_a: assert property ((!accel_active_in && err == 33'sh0) |=> analog_out == 16'sh0000)
    else $error("feed-forward without accel control");
  ferr_track_a: assert property (1'b1 |=> ferr_out == 32'($past(cmd_pos_in) - $past(meas_pos_in)))
    else $error("following error not command minus measured");

endmodule : apl_axis_gain

// ### hw/apl_position_loop.sv
// axis position loop: AHB-Lite register file, per-axis loops, alarm interrupt
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module apl_position_loop (
  // clock and reset
  input logic clk_in,
  input logic rst_in,
  // AHB-Lite slave
  input logic hsel_in,
  input logic [31:0] haddr_in,
  input logic [1:0] htrans_in,
  input logic hwrite_in,
  input logic [2:0] hsize_in,
  input logic [31:0] hwdata_in,
  input logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // axis inputs from the position logic
  input logic signed [31:0] cmd_pos_in [apl_pkg::AXES],
  input logic signed [31:0] meas_pos_in [apl_pkg::AXES],
  input logic signed [15:0] feed_in [apl_pkg::AXES],
  input logic [apl_pkg::AXES-1:0] accel_active_in,
  // axis outputs
  output logic signed [15:0] analog_out [apl_pkg::AXES],
  output logic [apl_pkg::AXES-1:0] alarm_out,
  output logic irq_out
);
  import apl_pkg::*;

  apl_axis_cfg_t cfg [AXES];
  apl_axis_cfg_t next_cfg [AXES];
  logic [AXES-1:0] status, next_status, enable, next_enable, alarm_q, clr;
  logic next_irq;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr, rd_addr, next_rd_addr;
  logic [31:0] next_hrdata, rd_word;
  logic [31:0] ferr [AXES];
  apl_rd_state_t rd_state, next_rd_state;
  logic accept;

  // ***************************
  // bus address phase
  // ***************************
  // reads take one wait state so read data always comes from a flip-flop
  assign accept = hsel_in && hready_in && htrans_in[1];
  assign hreadyout_out = (rd_state != RD_WAIT);
  assign hresp_out = 1'b0;

  always_comb begin
    next_wr_pend = accept && hwrite_in;
    next_wr_addr = accept ? haddr_in[7:0] : wr_addr;
    next_rd_addr = rd_addr;
    next_rd_state = RD_IDLE;
    case (rd_state)
      RD_IDLE, RD_DONE: begin
        if (accept && !hwrite_in) begin
          next_rd_addr = haddr_in[7:0];
          next_rd_state = RD_WAIT;
        end
      end
      RD_WAIT: begin
        next_rd_state = RD_DONE;
      end
      default: begin
        next_rd_state = RD_IDLE;
      end
    endcase
  end

  // ***************************
  // read multiplexer
  // ***************************
  // unmapped offsets read as zero; the clear register reads as zero too
  always_comb begin
    rd_word = 32'h0;
    case (rd_addr)
      OFS_IRQ_STATUS: rd_word = 32'(status);
      OFS_IRQ_ENABLE: rd_word = 32'(enable);
      OFS_ALARM: rd_word = 32'(alarm_out);
      default: rd_word = 32'h0;
    endcase
    for (int i = 0; i < AXES; i++) begin
      if (rd_addr[7:4] == 4'(int'(AXIS_SLOT0) + i)) begin
        case (rd_addr[3:0])
          OFS_GAINS: rd_word = {8'h00, cfg[i].feed_forward_gain, cfg[i].high_error_gain, cfg[i].low_error_gain};
          OFS_BREAK: rd_word = {16'h0000, cfg[i].gain_break_point};
          OFS_RAPID: rd_word = {16'h0000, cfg[i].max_rapid_feed};
          OFS_FERR: rd_word = ferr[i];
          default: rd_word = 32'h0;
        endcase
      end
    end
    next_hrdata = (rd_state == RD_WAIT) ? rd_word : hrdata_out;
  end

  // ***************************
  // register writes and interrupt
  // ***************************
  always_comb begin
    next_cfg = cfg;
    next_enable = enable;
    clr = '0;
    if (wr_pend) begin
      if (wr_addr == OFS_IRQ_CLEAR) begin
        clr = hwdata_in[AXES-1:0];
      end
      if (wr_addr == OFS_IRQ_ENABLE) begin
        next_enable = hwdata_in[AXES-1:0];
      end
      // a write reaches only the addressed axis
      for (int i = 0; i < AXES; i++) begin
        if (wr_addr[7:4] == 4'(int'(AXIS_SLOT0) + i)) begin
          case (wr_addr[3:0])
            OFS_GAINS: begin
              next_cfg[i].low_error_gain = hwdata_in[7:0];
              next_cfg[i].high_error_gain = hwdata_in[15:8];
              next_cfg[i].feed_forward_gain = hwdata_in[23:16];
            end
            OFS_BREAK: next_cfg[i].gain_break_point = hwdata_in[15:0];
            OFS_RAPID: next_cfg[i].max_rapid_feed = hwdata_in[15:0];
            default: next_cfg[i].max_rapid_feed = cfg[i].max_rapid_feed;
          endcase
        end
      end
    end
    // alarm onset is a sticky event; a new event beats a clear
    next_status = (status & ~clr) | (alarm_out & ~alarm_q);
    next_irq = |(next_status & next_enable);
  end

  // all bus and register state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < AXES; i++) begin
        cfg[i] <= '{RST_FF_GAIN, RST_HIGH_GAIN, RST_LOW_GAIN, RST_BREAK, RST_RAPID};
      end
      status <= '0;
      enable <= '0;
      alarm_q <= '0;
      irq_out <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      rd_state <= RD_IDLE;
      hrdata_out <= 32'h0;
    end else begin
      cfg <= next_cfg;
      status <= next_status;
      enable <= next_enable;
      alarm_q <= alarm_out;
      irq_out <= next_irq;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rd_addr <= next_rd_addr;
      rd_state <= next_rd_state;
      hrdata_out <= next_hrdata;
    end
  end

  // ***************************
  // axis loops
  // ***************************
  for (genvar g = 0; g < AXES; g++) begin : g_axis
    // each loop sees its own settings only
    apl_axis_gain u_axis (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg_in(cfg[g]),
      .cmd_pos_in(cmd_pos_in[g]),
      .meas_pos_in(meas_pos_in[g]),
      .feed_in(feed_in[g]),
      .accel_active_in(accel_active_in[g]),
      .analog_out(analog_out[g]),
      .alarm_out(alarm_out[g]),
      .ferr_out(ferr[g])
    );

    axis_isolate_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_pend && wr_addr[7:4] != 4'(int'(AXIS_SLOT0) + g)) |=> $stable(cfg[g]))
      else $error("write to another axis changed settings");
    alarm_event_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(alarm_out[g]) |=> status[g] ##1 (status[g] || $past(clr[g])))
      else $error("alarm onset not latched");
    set_wins_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (clr[g] && alarm_out[g] && !alarm_q[g]) |=> status[g])
      else $error("clear beat a new alarm event");
  end

  read_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && !hwrite_in) |=> !hreadyout_out ##1 (hreadyout_out && hresp_out == 1'b0))
    else $error("read not answered after one wait state");

endmodule : apl_position_loop

// ### verification/apl_drive_model.sv
// servo drive and encoder stand-in for the position loop bench
`timescale 1ns/1ps
module apl_drive_model (
  // clock and reset
  input logic clk_in,
  input logic rst_in,
  // bench control and loop command
  input logic run_in,
  input logic signed [31:0] pos_in [apl_pkg::AXES],
  input logic signed [15:0] analog_in [apl_pkg::AXES],
  // encoder position
  output logic signed [31:0] meas_out [apl_pkg::AXES]
);
  import apl_pkg::*;
  logic signed [31:0] next_meas [AXES];
  // full scale reaches rapid
  // idle: encoder parked where the bench puts it; run: drive integrates command
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      next_meas[a] = run_in ? meas_out[a] + 32'(analog_in[a] >>> 6) : pos_in[a];
    end
  end
  // encoder count register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meas_out <= '{default: '0};
    end else begin
      meas_out <= next_meas;
    end
  end
endmodule : apl_drive_model

// ### verification/apl_position_loop_tb_top.sv
// self-checking bench for the axis position loop
`timescale 1ns/1ps
module apl_position_loop_tb_top;
  import apl_pkg::*;
  // ***************************
  // signals and bench state
  // ***************************
  localparam longint LIM = FE_LIMIT_UM;
  logic clk_in, rst_in, hsel, hwrite, hrdy, hresp, irq, run;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic signed [31:0] cmd [AXES], mpos [AXES], meas [AXES];
  logic signed [15:0] feed [AXES], ana [AXES];
  logic [AXES-1:0] acc, alarm;
  longint ev [AXES];
  int cf [AXES][5];
  int n_errors = 0;
  int n_compared = 0;

  apl_position_loop apl_position_loop_i (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .cmd_pos_in(cmd), .meas_pos_in(meas),
    .feed_in(feed), .accel_active_in(acc), .analog_out(ana), .alarm_out(alarm), .irq_out(irq));
  apl_drive_model apl_drive_model_i (.clk_in(clk_in), .rst_in(rst_in), .run_in(run), .pos_in(mpos),
    .analog_in(ana), .meas_out(meas));

  // ***************************
  // helpers
  // ***************************
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask : chk
  // one single word transfer; waits last until ready, only the hang guard ends a stuck one
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    r = hrdata;
  endtask : ahb
  task automatic chkr(logic [31:0] a, logic [31:0] e, string m);
    ahb(1'b0, a, 32'h0, q);
    chk(q, e, m);
    chk(32'(hresp), 32'h0, "response");
  endtask : chkr
  // expected command from the axis settings kept by the bench
  function automatic longint expv(int a);
    longint m, p, v, f;
    m = ev[a] < 0 ? -ev[a] : ev[a];
    p = m <= cf[a][3] ? cf[a][0] * m : cf[a][0] * cf[a][3] + cf[a][1] * (m - cf[a][3]);
    v = (p * DAC_MUL) >> DAC_SHIFT;
    v = v > 32767 ? 32767 : v;
    v = ev[a] < 0 ? -v : v;
    f = feed[a] < 0 ? -feed[a] : feed[a];
    f = (cf[a][2] * (f > cf[a][4] ? cf[a][4] : f)) >> FF_SHIFT;
    v = acc[a] ? (feed[a] < 0 ? v - f : v + f) : v;
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction : expv
  // every axis is judged each time, so crosstalk between axes shows up too
  task automatic chk_axes();
    repeat (3) @(posedge clk_in);
    for (int a = 0; a < AXES; a++) begin
      chk(32'(ana[a]), 32'(expv(a)), "analog");
      chk(32'(alarm[a]), 32'(ev[a] > LIM || ev[a] < -LIM), "alarm");
    end
  endtask : chk_axes
  task automatic drive(int a, longint e, int f, logic ac);
    cmd[a] <= 32'(12345 + e);
    mpos[a] <= 32'sd12345;
    feed[a] <= 16'(f);
    acc[a] <= ac;
    ev[a] = e;
  endtask : drive
  task automatic cfg(int a, int lo, int hi, int fg, int b, int r);
    cf[a] = '{lo, hi, fg, b, r};
    ahb(1'b1, 32'(32 + 16 * a), 32'(fg << 16 | hi << 8 | lo), q);
    ahb(1'b1, 32'(36 + 16 * a), 32'(b), q);
    ahb(1'b1, 32'(40 + 16 * a), 32'(r), q);
  endtask : cfg

  // ***************************
  // scenarios
  // ***************************
  // reset settings, unmapped place, gain reference point
  task automatic t_regs();
    chkr(32'h20, 32'h4040, "gains");
    chkr(32'h24, 32'h3e8, "break");
    chkr(32'h28, 32'hffff, "rapid");
    chkr(32'hf0, 32'h0, "unmapped");
    drive(0, 1, 0, 1'b0);
    chk_axes();
    chk(32'(ana[0]), 32'(GAIN_REF_LSB), "reference");
  endtask : t_regs
  // both slopes around the break point, top low gain, clipping
  task automatic t_slopes();
    longint es [7] = '{0, 50, 100, 101, -101, -3000, -30000};
    cfg(1, 255, 16, 0, 100, 65535);
    chkr(32'h30, 32'h10ff, "readback");
    foreach (es[i]) begin
      drive(1, es[i], 0, 1'b0);
      chk_axes();
    end
    chkr(32'h3c, 32'(-30000), "ferr");
  endtask : t_slopes
  // feed-forward only under accel control, feed clipped, sum saturates
  task automatic t_ffwd();
    int sc [4][3] = '{'{10, 200, 0}, '{10, 200, 1}, '{10, -50, 1}, '{-30000, -200, 1}};
    cfg(2, 64, 64, 64, 1000, 100);
    foreach (sc[i]) begin
      drive(2, sc[i][0], sc[i][1], sc[i][2][0]);
      chk_axes();
    end
  endtask : t_ffwd
  // a zero-gain axis beside default ones (axes 0, 4) and ones set by earlier scenarios (axes 1, 2)
  task automatic t_isolate();
    cfg(3, 0, 0, 0, 1000, 65535);
    for (int a = 0; a < AXES; a++) begin
      drive(a, 500, 0, 1'b0);
    end
    chk_axes();
    // axis 3 past its break point with a flat high slope
    cfg(3, 32, 0, 0, 1000, 65535);
    drive(3, 1500, 0, 1'b0);
    chk_axes();
  endtask : t_isolate
  // limit edge, sticky status, mask, clear while the alarm stays
  task automatic t_alarm();
    drive(4, 32000, 0, 1'b0);
    chk_axes();
    chkr(32'h0, 32'h0, "quiet");
    drive(4, -32001, 0, 1'b0);
    chk_axes();
    chkr(32'h0, 32'h10, "onset");
    chk(32'(irq), 32'h0, "masked");
    ahb(1'b1, 32'h8, 32'h10, q);
    repeat (2) @(posedge clk_in);
    chk(32'(irq), 32'h1, "raised");
    chkr(32'hc, 32'h10, "live");
    ahb(1'b1, 32'h0, 32'h1f, q);
    ahb(1'b1, 32'h4, 32'h10, q);
    repeat (2) @(posedge clk_in);
    chk(32'(irq), 32'h0, "cleared");
    chkr(32'h0, 32'h0, "status");
    drive(4, 0, 0, 1'b0);
    chk_axes();
    // onset and clear land in the same cycle: the onset must stay latched
    drive(4, 40000, 0, 1'b0);
    ahb(1'b1, 32'h4, 32'h10, q);
    chkr(32'h0, 32'h10, "set wins");
  endtask : t_alarm
  // closed loop through the drive: error shrinks and keeps its sign
  task automatic t_loop();
    drive(0, 2000, 0, 1'b0);
    repeat (3) @(posedge clk_in);
    run <= 1'b1;
    repeat (40) @(posedge clk_in);
    ahb(1'b0, 32'h2c, 32'h0, q);
    chk(32'($signed(q) >= 0 && $signed(q) < 2000), 32'h1, "settle");
    run <= 1'b0;
  endtask : t_loop

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // hang guard, far above the roughly 170 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    final_report();
  end
  // main sequence
  initial begin
    rst_in = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    run = 1'b0;
    acc = '0;
    cmd = '{default: '0};
    mpos = '{default: '0};
    feed = '{default: '0};
    ev = '{default: 0};
    cf = '{default: '{64, 64, 0, 1000, 65535}};
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_slopes();
    t_ffwd();
    t_isolate();
    t_alarm();
    t_loop();
    final_report();
  end
endmodule : apl_position_loop_tb_top
